// ---- hdl/acsp_pkg.sv ----
// constants shared by the configuration serial port
package acsp_pkg;

	// ************************************************************
	// word layout
	// ************************************************************
	localparam int unsigned WORD_BITS  = 16;
	localparam int unsigned ADDR_BITS  = 8;
	localparam int unsigned DATA_BITS  = 8;
	localparam logic [3:0]  LAST_BIT   = 4'hf;
	localparam logic [3:0]  ADDR_DONE  = 4'h7;

	// ************************************************************
	// control register at address zero
	// ************************************************************
	localparam logic [7:0]  CTRL_ADDR      = 8'h00;
	localparam int unsigned READOUT_BIT    = 0;
	localparam int unsigned SOFT_RESET_BIT = 1;
	localparam logic [7:0]  REG_RESET_VAL  = 8'h00;

	// ************************************************************
	// four-level select pin codes from the level comparator
	// ************************************************************
	localparam logic [1:0]  SEL_LVL_GND      = 2'h0;
	localparam logic [1:0]  SEL_LVL_3_8      = 2'h1;
	localparam logic [1:0]  SEL_LVL_5_8      = 2'h2;
	localparam logic [1:0]  SEL_LVL_FULL     = 2'h3;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int unsigned CORE_CLK_MHZ     = 125;
	localparam int unsigned SCLK_MAX_MHZ     = 20;
	localparam int unsigned SYNC_STAGES      = 2;

endpackage : acsp_pkg

// ---- hdl/acsp_sync.sv ----
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
`default_nettype none

module acsp_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             core_clk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	// first stage feeds only the second stage
	always_comb
	begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	// register both stages
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;

endmodule : acsp_sync

`default_nettype wire

// ---- hdl/acsp_top.sv ----
// configuration serial port with parallel strap decode
// Overview of operation
// - parallel mode: shift-clock pin level selects low-speed
// - select pin four levels pick format, interface
// - power pins: normal, power-down, A standby
// - all power pins high: multiplexed output mode
// - shift bits only while select low, falling edge
// - every sixteenth falling edge commits the word
// - trailing partial word bits are discarded
// - several words per frame, each a write
// - first byte address, second byte data
// - shift clock up to 20 MHz, each phase longer than one 125 MHz core cycle
// - software reset bit clears all, self-clears
// - readback bit set blocks register writes except to address 0
// - readback shifts addressed register data out
// - clearing readback bit re-enables writes
// - serial output tristated while readback off
// - software reset is bit 1, address 0
// - readback enable is bit 0, address 0
// - all registers reset to zero
// - reset pin high: parallel; low: serial
`timescale 1ns/100ps
`default_nettype none

module acsp_top #(
	parameter int unsigned NUM_REGS = 256
) (
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	input  wire logic       serial_clk_pin,
	input  wire logic       serial_select_n,
	input  wire logic       serial_in_line,
	input  wire logic [1:0] select_level,
	input  wire logic       hw_reset_pin,
	input  wire logic       power_mode_pin_1,
	input  wire logic       power_mode_pin_2,
	input  wire logic       power_mode_pin_3,
	input  wire logic [7:0] cfg_rd_addr,
	output logic      [7:0] cfg_rd_data,
	output logic            serial_out_line,
	output logic            serial_out_oe_n,
	output logic            parallel_mode,
	output logic            low_speed_mode,
	output logic            twos_complement,
	output logic            lvds_output,
	output logic            global_power_down,
	output logic            chan_a_standby,
	output logic            mux_mode,
	output logic            power_mode_unavailable,
	output logic            readout_enable,
	output logic            write_strobe
);

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [8:0] pins_async;
	logic [8:0] pins_sync;
	logic       sclk_s;
	logic       sel_n_s;
	logic       serial_in_line_s;
	logic       rst_pin_s;
	logic [2:0] pwr_s;
	logic [1:0] lvl_s;

	assign pins_async = {select_level, power_mode_pin_3, power_mode_pin_2, power_mode_pin_1,
	                     hw_reset_pin, serial_in_line, serial_select_n, serial_clk_pin};

	acsp_sync #(
		.WIDTH (9)
	) u_sync (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.async_in (pins_async),
		.sync_out (pins_sync)
	);

	assign sclk_s    = pins_sync[0];
	assign sel_n_s   = pins_sync[1];
	assign serial_in_line_s   = pins_sync[2];
	assign rst_pin_s = pins_sync[3];
	assign pwr_s     = pins_sync[6:4];
	assign lvl_s     = pins_sync[8:7];

	// ************************************************************
	// shift-clock edge detection and frame state
	// ************************************************************
	logic [7:0]  regs_q [NUM_REGS];
	logic        sclk_prev_q;
	logic        sclk_prev_d;
	logic [3:0]  bit_cnt_q;
	logic [3:0]  bit_cnt_d;
	logic [14:0] shift_q;
	logic [14:0] shift_d;
	logic [7:0]  out_sh_q;
	logic [7:0]  out_sh_d;
	logic        sclk_fall;
	logic [15:0] word;
	logic        commit;
	logic        wr_allow;
	logic        soft_rst;
	logic        clear_all;
	logic [7:0]  rd_addr_word;

	// a falling edge seen on the synchronised clock, sampled at 125 MHz
	assign sclk_fall = sclk_prev_q && !sclk_s;
	assign word      = {shift_q, serial_in_line_s};
	assign commit    = sclk_fall && !sel_n_s && (bit_cnt_q == acsp_pkg::LAST_BIT);
	assign rd_addr_word = {shift_q[6:0], serial_in_line_s};

	// next values of the serial shifter
	always_comb
	begin
		sclk_prev_d = sclk_s;
		bit_cnt_d   = bit_cnt_q;
		shift_d     = shift_q;
		out_sh_d    = out_sh_q;
		if (sel_n_s)
		begin
			bit_cnt_d = 4'h0;
		end
		else if (sclk_fall)
		begin
			shift_d   = {shift_q[13:0], serial_in_line_s};
			bit_cnt_d = bit_cnt_q + 4'h1;
			if (bit_cnt_q == acsp_pkg::ADDR_DONE)
			begin
				out_sh_d = regs_q[rd_addr_word];
			end
			else
			begin
				out_sh_d = {out_sh_q[6:0], 1'b0};
			end
		end
	end

	// register the shifter
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			sclk_prev_q <= 1'b0;
			bit_cnt_q   <= 4'h0;
			shift_q     <= 15'h0000;
			out_sh_q    <= 8'h00;
		end
		else
		begin
			sclk_prev_q <= sclk_prev_d;
			bit_cnt_q   <= bit_cnt_d;
			shift_q     <= shift_d;
			out_sh_q    <= out_sh_d;
		end
	end

	// ************************************************************
	// register file
	// ************************************************************
	// writes blocked in readback except to the control register
	assign wr_allow = !readout_enable || (word[15:8] == acsp_pkg::CTRL_ADDR);
	assign soft_rst = commit && wr_allow && (word[15:8] == acsp_pkg::CTRL_ADDR)
	                  && word[acsp_pkg::SOFT_RESET_BIT];
	// hardware pin, core reset or software bit all clear the map
	assign clear_all = rst_pin_s || soft_rst;

	always_ff @(posedge core_clk)
	begin
		if (!reset_n || clear_all)
		begin
			for (int i = 0; i < NUM_REGS; i++)
			begin
				regs_q[i] <= acsp_pkg::REG_RESET_VAL;
			end
		end
		else if (commit && wr_allow)
		begin
			regs_q[word[15:8]] <= word[7:0];
		end
	end

	// core-side read port and write pulse
	logic [7:0] rd_data_q;
	logic [7:0] rd_data_d;
	logic       wr_stb_q;
	logic       wr_stb_d;

	always_comb
	begin
		rd_data_d = regs_q[cfg_rd_addr];
		wr_stb_d  = commit && wr_allow && !rst_pin_s;
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			rd_data_q <= 8'h00;
			wr_stb_q  <= 1'b0;
		end
		else
		begin
			rd_data_q <= rd_data_d;
			wr_stb_q  <= wr_stb_d;
		end
	end

	assign cfg_rd_data    = rd_data_q;
	assign write_strobe   = wr_stb_q;
	assign readout_enable = regs_q[acsp_pkg::CTRL_ADDR][acsp_pkg::READOUT_BIT];

	// ************************************************************
	// serial output pin
	// ************************************************************
	logic sdo_q;
	logic sdo_d;
	logic oe_n_q;
	logic oe_n_d;

	// drive only in readback, high impedance otherwise
	always_comb
	begin
		sdo_d  = readout_enable ? out_sh_q[7] : 1'b0;
		oe_n_d = !readout_enable;
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			sdo_q  <= 1'b0;
			oe_n_q <= 1'b1;
		end
		else
		begin
			sdo_q  <= sdo_d;
			oe_n_q <= oe_n_d;
		end
	end

	assign serial_out_line = sdo_q;
	assign serial_out_oe_n = oe_n_q;

	// ************************************************************
	// parallel strap decode
	// ************************************************************
	logic [7:0] strap_q;
	logic [7:0] strap_d;

	always_comb
	begin
		strap_d    = 8'h00;
		strap_d[0] = rst_pin_s;
		strap_d[1] = rst_pin_s && sclk_s;
		case (lvl_s)
			acsp_pkg::SEL_LVL_GND:  strap_d[3:2] = 2'b01;
			acsp_pkg::SEL_LVL_3_8:  strap_d[3:2] = 2'b00;
			acsp_pkg::SEL_LVL_5_8:  strap_d[3:2] = 2'b10;
			acsp_pkg::SEL_LVL_FULL: strap_d[3:2] = 2'b11;
			default:                strap_d[3:2] = 2'b01;
		endcase
		case (pwr_s) // {pin3, pin2, pin1}
			3'b000:  strap_d[7:4] = 4'h0;
			3'b001:  strap_d[7:4] = 4'h1;
			3'b101:  strap_d[7:4] = 4'h2;
			3'b111:  strap_d[7:4] = 4'h4;
			default: strap_d[7:4] = 4'h8;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			strap_q <= 8'h00;
		end
		else
		begin
			strap_q <= strap_d;
		end
	end

	assign parallel_mode          = strap_q[0];
	assign low_speed_mode         = strap_q[1];
	assign twos_complement        = strap_q[2];
	assign lvds_output            = strap_q[3];
	assign global_power_down      = strap_q[4];
	assign chan_a_standby         = strap_q[5];
	assign mux_mode               = strap_q[6];
	assign power_mode_unavailable = strap_q[7];

endmodule : acsp_top

`default_nettype wire

// ---- verification/acsp_top_chk.sv ----
// assertion checker for the configuration serial port
`timescale 1ns/100ps
`default_nettype none

module acsp_top_chk (
	input wire logic       core_clk,
	input wire logic       reset_n,
	input wire logic       serial_clk_pin,
	input wire logic [1:0] select_level,
	input wire logic       hw_reset_pin,
	input wire logic       power_mode_pin_1,
	input wire logic       power_mode_pin_2,
	input wire logic       power_mode_pin_3,
	input wire logic [7:0] cfg_rd_addr,
	input wire logic [7:0] cfg_rd_data,
	input wire logic       serial_out_oe_n,
	input wire logic       parallel_mode,
	input wire logic       low_speed_mode,
	input wire logic       twos_complement,
	input wire logic       lvds_output,
	input wire logic       global_power_down,
	input wire logic       chan_a_standby,
	input wire logic       mux_mode,
	input wire logic       power_mode_unavailable,
	input wire logic       readout_enable,
	input wire logic       write_strobe
);
	// ****
	// properties
	// ****
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	// power pins as {pin3, pin2, pin1}
	wire [2:0] pins = {power_mode_pin_3, power_mode_pin_2, power_mode_pin_1};

	format_decode_a: assert property ((reset_n && $stable(select_level))[*5] |->
		{twos_complement, lvds_output} == {select_level[1] ~^ select_level[0], select_level[1]}) else $error("format");
	power_decode_a: assert property ((reset_n && $stable(pins))[*5] |->
		{global_power_down, chan_a_standby, mux_mode, power_mode_unavailable}
		== {pins == 3'h1, pins == 3'h5, &pins, pins inside {3'h2, 3'h3, 3'h4, 3'h6}}) else $error("power");
	low_speed_a: assert property ((reset_n && $stable({hw_reset_pin, serial_clk_pin}))[*5] |->
		low_speed_mode == (hw_reset_pin && serial_clk_pin)) else $error("low speed");
	parallel_sel_a: assert property ($stable(hw_reset_pin)[*4] |-> parallel_mode == hw_reset_pin)
		else $error("parallel mode");
	readout_oe_a: assert property ($stable(readout_enable)[*3] |-> serial_out_oe_n == !readout_enable)
		else $error("output enable");
	strobe_pulse_a: assert property (write_strobe |=> !write_strobe) else $error("strobe");
	soft_clear_a: assert property (cfg_rd_addr == 8'h00 ##1 cfg_rd_addr == 8'h00 |=> !cfg_rd_data[1])
		else $error("reset bit");
	hw_clear_a: assert property (hw_reset_pin[*5] |=> cfg_rd_data == 8'h00) else $error("hw reset");
endmodule : acsp_top_chk

bind acsp_top acsp_top_chk u_chk (.*);

`default_nettype wire

// ---- verification/acsp_ctl_model.sv ----
// serial controller model for the configuration port
`timescale 1ns/100ps
`default_nettype none

module acsp_ctl_model (
	output logic        sclk,
	output logic        sel_n,
	output logic        sdi,
	input  wire logic   sdo,
	output logic [15:0] rx
);
	// ****
	// frame driver
	// ****
	// idle: clock low, deselected
	initial {sclk, sel_n, sdi, rx} = {3'h2, 16'h0000};

	// n bits msb first, given low and high times
	task automatic xfer(input logic [63:0] w, input int n, input realtime lo, input realtime hi);
		sel_n = 1'b0;
		#lo;
		for (int i = n - 1; i >= 0; i--)
		begin
			sdi = w[i];
			sclk = 1'b1;
			#hi;
			rx = {rx[14:0], sdo};
			sclk = 1'b0;
			#lo;
		end
		sel_n = 1'b1;
		sdi = ~sdi; // released line drops the last bit
	endtask : xfer
endmodule : acsp_ctl_model

`default_nettype wire

// ---- verification/acsp_top_test.sv ----
// self-checking bench for the configuration serial port
`timescale 1ns/100ps
`default_nettype none

module acsp_top_test;
	// ****
	// bench state
	// ****
	logic        core_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        hw_reset_pin = 1'b1;
	logic        power_mode_pin_1 = 1'b0, power_mode_pin_2 = 1'b0, power_mode_pin_3 = 1'b0;
	logic [1:0]  select_level = 2'h0;
	logic [7:0]  cfg_rd_addr = 8'h00;
	logic [7:0]  cfg_rd_data, got, ex, a1, a2, d1, d2;
	logic [7:0]  exp_q[$];
	logic [31:0] rs = 32'h14;
	logic        serial_out_line, serial_out_oe_n, parallel_mode, low_speed_mode, twos_complement, lvds_output;
	logic        global_power_down, chan_a_standby, mux_mode, power_mode_unavailable, readout_enable, write_strobe;
	wire         serial_clk_pin, serial_select_n, serial_in_line, sdo;
	wire [7:0]   strap = {2'h0, twos_complement, lvds_output, global_power_down, chan_a_standby, mux_mode,
		power_mode_unavailable};
	int          err_count = 0, num_checks = 0, strobes = 0, n0;
	event        got_ev;

	// design, controller and readback pin
	acsp_top dut (.*);
	acsp_ctl_model u_m (.sclk(serial_clk_pin), .sel_n(serial_select_n), .sdi(serial_in_line), .sdo(sdo), .rx());
	assign sdo = serial_out_oe_n ? ~serial_out_line : serial_out_line; // released pin shows the inverse
	always #4 core_clk = ~core_clk;
	always @(posedge core_clk) if (write_strobe === 1'b1) strobes++;

	// compares each result with the oldest note
	always @(got_ev)
	begin
		num_checks++;
		if (got !== exp_q[0])
		begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp_q[0]);
		end
		void'(exp_q.pop_front());
	end

	// ****
	// tasks
	// ****
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	task automatic cmp(input logic [7:0] g, input logic [7:0] e);
		exp_q.push_back(e);
		got = g;
		->got_ev;
		#1;
	endtask : cmp

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk) cfg_rd_addr <= a;
		repeat (2) @(posedge core_clk);
		#1 cmp(cfg_rd_data, e);
	endtask : rd

	// one word at 20 MHz, then time to commit
	task automatic wr(input logic [15:0] w);
		u_m.xfer({48'h0, w}, 16, 25.0, 25.0);
		repeat (8) @(posedge core_clk);
	endtask : wr

	task automatic pulse();
		@(posedge core_clk) hw_reset_pin <= 1'b1;
		repeat (3) @(posedge core_clk);
		hw_reset_pin <= 1'b0;
		repeat (13) @(posedge core_clk);
	endtask : pulse

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim

	// ****
	// sequence
	// ****
	initial
	begin
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			@(posedge core_clk);
			select_level <= 2'(i);
			{power_mode_pin_3, power_mode_pin_2, power_mode_pin_1} <= 3'(i);
			ex = {2'h0, 2'(8'hd2 >> (2 * (i % 4))), 4'(32'h2141_1180 >> (4 * i))};
			repeat (6) @(posedge core_clk);
			#1 cmp(strap, ex);
		end
		for (int s = 1; s >= 0; s--)
		begin
			@(posedge core_clk) u_m.sclk <= s[0];
			repeat (6) @(posedge core_clk);
			#1 cmp({6'h0, parallel_mode, low_speed_mode}, {7'h01, s[0]});
		end
		$display("strap test done");
		@(posedge core_clk) hw_reset_pin <= 1'b0;
		pulse(); // supplies taken as settled long before
		rs = xs(rs);
		a1 = rs[7:0] | 8'h01;
		a2 = a1 ^ 8'h80;
		{d2, d1} = rs[23:8];
		n0 = strobes;
		u_m.xfer({27'h0, a1, d1, a2, d2, 5'h1f}, 37, 30.0, 95.0);
		repeat (6) @(posedge core_clk);
		cmp(8'(strobes - n0), 8'h02);
		rd(a1, d1);
		rd(a2, d2);
		wr({a1, ~d1});
		rd(a1, ~d1);
		$display("write test done");
		wr(16'h0001);
		#1 cmp({6'h0, readout_enable, serial_out_oe_n}, 8'h02);
		n0 = strobes;
		wr({a2, d1});
		cmp(8'(strobes - n0), 8'h00);
		rd(a2, d2);
		u_m.xfer({48'h0, a1, 8'h00}, 16, 30.0, 95.0);
		cmp(u_m.rx[7:0], ~d1);
		wr(16'h0000);
		#1 cmp({6'h0, readout_enable, serial_out_oe_n}, 8'h01);
		wr({a2, d1});
		rd(a2, d1);
		$display("readback test done");
		wr(16'h0002);
		rd(a2, 8'h00);
		rd(8'h00, 8'h00);
		wr({a1, d2});
		pulse();
		rd(a1, 8'h00);
		$display("reset test done");
		end_sim();
	end
endmodule : acsp_top_test

`default_nettype wire
